/* File: logic/imf_pkg.sv */
// imf_pkg: constants and carriers of the interrupt mask and flag unit
// assumes an Avalon-MM byte-addressed slave port, one 8-bit register a word
//
// Behaviour
// - ext irq requested only with mask bit 6 and global enable; vector 1
// - two sense bits pick rising, falling, any change or low level
// - ext pin activity counts even when the pin is driven as output
// - mask bit 5 gates pb7-4, pa7-6, pa3 changes onto vector 2
// - mask bit 4 gates pb3-0 changes onto shared vector 2
// - pin with alternate function enabled never sets pin-change flag
// - reserved bits of mask and flag registers read zero, writes ignored
// - ext flag bit 6 set on event, cleared by vectoring or write one
// - ext flag held zero while low-level sensing selected
// - pin-change flag bit 5 set on event, cleared by vectoring or write one
// - disabled pin-change group never sets the pin-change flag
// - t1 match a taken at vector 3 with mask bit 6, flag, global enable
// - t1 match b taken at vector 4 with mask bit 5, flag, global enable
// - t1 wrap taken at vector 5 with mask bit 2, flag, global enable
// - t0 wrap taken at vector 6 with mask bit 1, flag, global enable
// - flag bit 6 set on match a; write-one clears one cycle later
// - flag bit 5 set on match b; write-one clears one cycle later
// - flag bit 2 set on t1 wrap; write-one clears one cycle later
// - flag bit 1 set on t0 wrap; write-one clears at once
// - low-level mode keeps requesting while the ext pin stays low
// - wake only when two watchdog-tick samples show the required level
// - taking an irq clears global enable; return instruction sets it
// - lowest pending vector served first, ext before all others
package imf_pkg;

  localparam logic [7:0] OFS_GEN_MASK = 8'h2c;
  localparam logic [7:0] OFS_GEN_FLAGS = 8'h30;
  localparam logic [7:0] OFS_TMR_MASK = 8'h34;
  localparam logic [7:0] OFS_TMR_FLAGS = 8'h38;
  localparam logic [7:0] OFS_STATUS = 8'h3c;
  localparam logic [7:0] OFS_CONTROL = 8'h40;

  localparam int BIT_EXT = 6;
  localparam int BIT_PC_UP = 5;
  localparam int BIT_PC_LO = 4;
  localparam int BIT_EXT_FLAG = 6;
  localparam int BIT_PC_FLAG = 5;
  localparam int BIT_T1A = 6;
  localparam int BIT_T1B = 5;
  localparam int BIT_T1W = 2;
  localparam int BIT_T0W = 1;
  localparam int BIT_GIE = 7;

  localparam logic [7:0] GEN_MASK_BITS = 8'h70;
  localparam logic [7:0] GEN_FLAG_BITS = 8'h60;
  localparam logic [7:0] TMR_BITS = 8'h66;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [1:0] RST_SENSE = 2'h0;
  localparam int N_PC = 11;
  localparam int N_PC_LO = 4;
  localparam logic [1:0] WAKE_SAMPLES = 2'h2;

  typedef enum logic [1:0] {
    SENSE_LOW = 2'h0,
    SENSE_ANY = 2'h1,
    SENSE_FALL = 2'h2,
    SENSE_RISE = 2'h3
  } imf_sense_e;

  typedef enum logic [2:0] {
    VEC_NONE = 3'h0,
    VEC_EXT = 3'h1,
    VEC_PINCHG = 3'h2,
    VEC_T1A = 3'h3,
    VEC_T1B = 3'h4,
    VEC_T1W = 3'h5,
    VEC_T0W = 3'h6
  } imf_vec_e;

  typedef struct packed {
    logic t1_match_a;
    logic t1_match_b;
    logic t1_wrap;
    logic t0_wrap;
  } imf_tmr_evt_s;

  typedef struct packed {
    logic [7:0] gen_mask;
    logic [7:0] gen_flags;
    logic [7:0] tmr_mask;
    logic [7:0] tmr_flags;
    logic [7:0] tmr_clr_pend;
    logic gie;
    imf_sense_e sense;
    logic [N_PC-1:0] pc_prev;
    logic ext_prev;
    logic [7:0] rd_data;
    logic ack;
    logic irq_req;
    imf_vec_e irq_vec;
    logic [1:0] wake_cnt;
    logic wake_level;
    logic wake;
  } imf_state_s;

endpackage

/* File: logic/imf_unit.sv */
// imf_unit: interrupt mask, flag, sensing, priority and wake logic
// assumes synchronous pin inputs, cpu pulses irq_ack for the shown vector
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module imf_unit import imf_pkg::*; (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic ext_pin_in,
  input wire logic [7:0] port_a_pins,
  input wire logic [7:0] port_b_pins,
  input wire logic [N_PC-1:0] alt_fn_active,
  input wire imf_tmr_evt_s tmr_evt,
  input wire logic irq_ack,
  input wire logic return_from_irq_instr,
  input wire logic sleeping,
  input wire logic wdt_osc_tick,
  output logic irq_req,
  output imf_vec_e irq_vector,
  output logic global_irq_enable,
  output logic wake_req
);

  imf_state_s st_r;
  imf_state_s st_nxt;
  logic [N_PC-1:0] pc_pins;
  logic [N_PC-1:0] pc_hit;
  logic ext_evt;
  logic level_mode;
  logic ext_low_req;
  logic [6:1] pend;
  logic wr_lane;
  logic acc;
  logic wake_want;

  ////////////////////////////////////////////////////////////////////////////
  // pin change qualification
  assign pc_pins = {port_a_pins[7:6], port_a_pins[3], port_b_pins};

  generate
    for (genvar i = 0; i < N_PC; i++) begin : g_pc
      if (i < N_PC_LO) begin : g_lo
        // lower group gated by its own enable
        assign pc_hit[i] = (pc_pins[i] ^ st_r.pc_prev[i]) &
          ~alt_fn_active[i] & st_r.gen_mask[BIT_PC_LO];
      end else begin : g_up
        // upper group gated by its own enable
        assign pc_hit[i] = (pc_pins[i] ^ st_r.pc_prev[i]) &
          ~alt_fn_active[i] & st_r.gen_mask[BIT_PC_UP];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // external pin sensing; pin level used whatever its direction
  assign level_mode = (st_r.sense == SENSE_LOW);
  always_comb begin
    unique case (st_r.sense)
      SENSE_ANY: ext_evt = ext_pin_in ^ st_r.ext_prev;
      SENSE_FALL: ext_evt = st_r.ext_prev & ~ext_pin_in;
      SENSE_RISE: ext_evt = ~st_r.ext_prev & ext_pin_in;
      SENSE_LOW: ext_evt = 1'b0;
    endcase
  end
  assign ext_low_req = level_mode & ~ext_pin_in;

  ////////////////////////////////////////////////////////////////////////////
  // pending, enabled sources by vector
  assign pend[1] = st_r.gen_mask[BIT_EXT] &
    (st_r.gen_flags[BIT_EXT_FLAG] | ext_low_req);
  assign pend[2] = st_r.gen_flags[BIT_PC_FLAG] &
    (st_r.gen_mask[BIT_PC_UP] | st_r.gen_mask[BIT_PC_LO]);
  assign pend[3] = st_r.tmr_mask[BIT_T1A] & st_r.tmr_flags[BIT_T1A];
  assign pend[4] = st_r.tmr_mask[BIT_T1B] & st_r.tmr_flags[BIT_T1B];
  assign pend[5] = st_r.tmr_mask[BIT_T1W] & st_r.tmr_flags[BIT_T1W];
  assign pend[6] = st_r.tmr_mask[BIT_T0W] & st_r.tmr_flags[BIT_T0W];

  ////////////////////////////////////////////////////////////////////////////
  // bus and wake helpers
  assign acc = (avs_read | avs_write) & ~st_r.ack;
  assign wr_lane = avs_write & avs_byteenable[0] & st_r.ack;
  always_comb begin
    unique case (st_r.sense)
      SENSE_RISE: wake_want = 1'b1;
      SENSE_ANY: wake_want = ~st_r.wake_level;
      SENSE_LOW: wake_want = 1'b0;
      SENSE_FALL: wake_want = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic [7:0] wd;
    logic ack_ext;
    logic ack_pc;
    logic ack_t0;
    wd = avs_writedata[7:0];
    ack_ext = 1'b0;
    ack_pc = 1'b0;
    ack_t0 = 1'b0;
    st_nxt = st_r;
    st_nxt.pc_prev = pc_pins;
    st_nxt.ext_prev = ext_pin_in;
    st_nxt.ack = acc;
    st_nxt.wake = 1'b0;

    // register writes; reserved bits stay zero
    if (wr_lane && avs_address == OFS_GEN_MASK) begin
      st_nxt.gen_mask = wd & GEN_MASK_BITS;
    end
    if (wr_lane && avs_address == OFS_TMR_MASK) begin
      st_nxt.tmr_mask = wd & TMR_BITS;
    end
    if (wr_lane && avs_address == OFS_CONTROL) begin
      st_nxt.sense = imf_sense_e'(wd[1:0]);
    end
    if (wr_lane && avs_address == OFS_STATUS) begin
      st_nxt.gie = wd[BIT_GIE];
    end

    // vectoring clears the served flag and the global enable
    if (irq_ack && st_r.irq_req) begin
      st_nxt.gie = 1'b0;
      ack_ext = (st_r.irq_vec == VEC_EXT);
      ack_pc = (st_r.irq_vec == VEC_PINCHG);
      ack_t0 = (st_r.irq_vec == VEC_T0W);
      if (st_r.irq_vec == VEC_T1A) st_nxt.tmr_flags[BIT_T1A] = 1'b0;
      if (st_r.irq_vec == VEC_T1B) st_nxt.tmr_flags[BIT_T1B] = 1'b0;
      if (st_r.irq_vec == VEC_T1W) st_nxt.tmr_flags[BIT_T1W] = 1'b0;
    end
    if (return_from_irq_instr) begin
      st_nxt.gie = 1'b1;
    end

    // general flags: write one clears, then event sets
    if ((wr_lane && avs_address == OFS_GEN_FLAGS && wd[BIT_EXT_FLAG]) ||
        ack_ext) begin
      st_nxt.gen_flags[BIT_EXT_FLAG] = 1'b0;
    end
    if ((wr_lane && avs_address == OFS_GEN_FLAGS && wd[BIT_PC_FLAG]) ||
        ack_pc) begin
      st_nxt.gen_flags[BIT_PC_FLAG] = 1'b0;
    end
    if (ext_evt) st_nxt.gen_flags[BIT_EXT_FLAG] = 1'b1;
    if (|pc_hit) st_nxt.gen_flags[BIT_PC_FLAG] = 1'b1;
    if (level_mode) st_nxt.gen_flags[BIT_EXT_FLAG] = 1'b0;

    // timer flags: t1 clears one cycle after write, t0 at once
    st_nxt.tmr_clr_pend = RST_REG;
    if (wr_lane && avs_address == OFS_TMR_FLAGS) begin
      st_nxt.tmr_clr_pend = wd & TMR_BITS &
        ~(8'h01 << BIT_T0W);
      if (wd[BIT_T0W]) st_nxt.tmr_flags[BIT_T0W] = 1'b0;
    end
    if (ack_t0) st_nxt.tmr_flags[BIT_T0W] = 1'b0;
    st_nxt.tmr_flags = st_nxt.tmr_flags & ~st_r.tmr_clr_pend;
    if (tmr_evt.t1_match_a) st_nxt.tmr_flags[BIT_T1A] = 1'b1;
    if (tmr_evt.t1_match_b) st_nxt.tmr_flags[BIT_T1B] = 1'b1;
    if (tmr_evt.t1_wrap) st_nxt.tmr_flags[BIT_T1W] = 1'b1;
    if (tmr_evt.t0_wrap) st_nxt.tmr_flags[BIT_T0W] = 1'b1;

    // read data captured in the waiting cycle; reserved bits zero
    st_nxt.rd_data = RST_REG;
    if (acc && avs_read) begin
      unique case (avs_address)
        OFS_GEN_MASK: st_nxt.rd_data = st_r.gen_mask;
        OFS_GEN_FLAGS: st_nxt.rd_data = st_r.gen_flags;
        OFS_TMR_MASK: st_nxt.rd_data = st_r.tmr_mask;
        OFS_TMR_FLAGS: st_nxt.rd_data = st_r.tmr_flags;
        OFS_STATUS: st_nxt.rd_data = {st_r.gie, 7'h00};
        OFS_CONTROL: st_nxt.rd_data = {6'h00, st_r.sense};
        default: st_nxt.rd_data = RST_REG;
      endcase
    end

    // fixed priority, lowest vector first, under global enable
    st_nxt.irq_req = 1'b0;
    st_nxt.irq_vec = VEC_NONE;
    if (st_nxt.gie) begin
      st_nxt.irq_req = |pend;
      if (pend[1]) st_nxt.irq_vec = VEC_EXT;
      else if (pend[2]) st_nxt.irq_vec = VEC_PINCHG;
      else if (pend[3]) st_nxt.irq_vec = VEC_T1A;
      else if (pend[4]) st_nxt.irq_vec = VEC_T1B;
      else if (pend[5]) st_nxt.irq_vec = VEC_T1W;
      else if (pend[6]) st_nxt.irq_vec = VEC_T0W;
    end

    // wake: two watchdog-tick samples at the required level
    if (!sleeping) begin
      st_nxt.wake_cnt = 2'h0;
      st_nxt.wake_level = ext_pin_in;
    end else if (wdt_osc_tick && st_r.gen_mask[BIT_EXT]) begin
      if (ext_pin_in == wake_want) begin
        st_nxt.wake_cnt = st_r.wake_cnt + 2'h1;
        if (st_r.wake_cnt + 2'h1 == WAKE_SAMPLES) begin
          st_nxt.wake = 1'b1;
          st_nxt.wake_cnt = 2'h0;
        end
      end else begin
        st_nxt.wake_cnt = 2'h0;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_r <= '{gen_mask: RST_REG, gen_flags: RST_REG, tmr_mask: RST_REG,
        tmr_flags: RST_REG, tmr_clr_pend: RST_REG, gie: 1'b0,
        sense: SENSE_LOW, pc_prev: '0, ext_prev: 1'b0, rd_data: RST_REG,
        ack: 1'b0, irq_req: 1'b0, irq_vec: VEC_NONE, wake_cnt: 2'h0,
        wake_level: 1'b0, wake: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign avs_waitrequest = (avs_read | avs_write) & ~st_r.ack;
  assign avs_readdata = {24'h000000, st_r.rd_data};
  assign irq_req = st_r.irq_req;
  assign irq_vector = st_r.irq_vec;
  assign global_irq_enable = st_r.gie;
  assign wake_req = st_r.wake;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_ext_needs_gie: assert property (
    irq_req |-> global_irq_enable)
    else $error("irq request without global enable");
  a_ext_level_hold: assert property (
    st_r.gie && st_r.gen_mask[BIT_EXT] && level_mode && !ext_pin_in &&
    !irq_ack && !return_from_irq_instr |=> irq_req && irq_vector == VEC_EXT)
    else $error("low level not requesting ext vector");
  a_ext_flag_level: assert property (
    $past(level_mode) |-> !st_r.gen_flags[BIT_EXT_FLAG])
    else $error("ext flag set in level mode");
  a_reserved_zero: assert property (
    (st_r.gen_mask & ~GEN_MASK_BITS) == 8'h00 &&
    (st_r.tmr_flags & ~TMR_BITS) == 8'h00 &&
    (st_r.gen_flags & ~GEN_FLAG_BITS) == 8'h00)
    else $error("reserved bit set");
  a_pc_group_gate: assert property (
    !st_r.gen_mask[BIT_PC_UP] && !st_r.gen_mask[BIT_PC_LO] &&
    !st_r.gen_flags[BIT_PC_FLAG] |=> !st_r.gen_flags[BIT_PC_FLAG])
    else $error("pin-change flag set by disabled group");
  a_t1a_sync_clr: assert property (
    wr_lane && avs_address == OFS_TMR_FLAGS && avs_writedata[BIT_T1A] &&
    st_r.tmr_flags[BIT_T1A] && !tmr_evt.t1_match_a
    |=> st_r.tmr_flags[BIT_T1A] ##1
    (!st_r.tmr_flags[BIT_T1A] || $past(tmr_evt.t1_match_a)))
    else $error("t1 match a clear timing wrong");
  a_t0_direct_clr: assert property (
    wr_lane && avs_address == OFS_TMR_FLAGS && avs_writedata[BIT_T0W] &&
    !tmr_evt.t0_wrap |=> !st_r.tmr_flags[BIT_T0W])
    else $error("t0 wrap flag not cleared at once");
  a_set_wins: assert property (
    tmr_evt.t0_wrap |=> st_r.tmr_flags[BIT_T0W])
    else $error("t0 wrap event lost");
  a_ack_drops_gie: assert property (
    irq_ack && irq_req && !return_from_irq_instr |=> !global_irq_enable)
    else $error("global enable kept after vectoring");
  a_prio_order: assert property (
    irq_req && st_r.tmr_flags[BIT_T1A] && st_r.tmr_mask[BIT_T1A]
    |-> irq_vector <= VEC_T1A)
    else $error("lower priority vector served first");
  a_wake_two: assert property (
    wake_req |-> $past(sleeping) && $past(wdt_osc_tick))
    else $error("wake without sampled tick");
  a_bus_one_wait: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer not after one wait cycle");

  c_ext_taken: cover property (irq_ack && irq_vector == VEC_EXT);
  c_pc_taken: cover property (irq_ack && irq_vector == VEC_PINCHG);
  c_t1a_clear: cover property (st_r.tmr_clr_pend[BIT_T1A]);
  c_wake: cover property (wake_req);

endmodule // imf_unit

/* File: tb/imf_cpu_model.sv */
// imf_cpu_model: core side that takes vectors and returns from handlers
// assumes registered irq_req and irq_vector from the unit, same clock
`timescale 1ns/100ps
module imf_cpu_model import imf_pkg::*; (
  input wire logic mclk,
  input wire logic reset,
  input wire logic irq_req,
  input wire imf_vec_e irq_vector,
  input wire logic auto_en,
  input wire logic [2:0] ack_dly,
  output logic irq_ack,
  output logic return_from_irq_instr,
  output imf_vec_e last_vec,
  output logic [7:0] n_taken
);
  logic [2:0] cnt;
  logic [2:0] ret_cnt;
  logic take;

  assign take = irq_req && auto_en && !irq_ack;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      {irq_ack, return_from_irq_instr, cnt, ret_cnt, n_taken} <= '0;
      last_vec <= VEC_NONE;
    end else begin
      irq_ack <= 1'b0;
      return_from_irq_instr <= 1'b0;
      cnt <= take ? cnt + 3'h1 : 3'h0;
      if (ret_cnt != 3'h0) ret_cnt <= ret_cnt - 3'h1;
      if (ret_cnt == 3'h1) return_from_irq_instr <= 1'b1;
      if (take && cnt == ack_dly) begin
        irq_ack <= 1'b1;
        last_vec <= irq_vector;
        n_taken <= n_taken + 8'h1;
        cnt <= 3'h0;
        ret_cnt <= 3'h4;
      end
    end
  end
endmodule // imf_cpu_model

/* File: tb/imf_unit_tb_top.sv */
// imf_unit_tb_top: self-checking bench of the interrupt mask and flag unit
// assumes imf_pkg, imf_unit and imf_cpu_model compiled before it
`timescale 1ns/100ps
module imf_unit_tb_top import imf_pkg::*; ;
  logic mclk, reset, rdq, wrq, wreq, ext_pin_in, sleeping, tick, ack, ret;
  logic irq_req, global_irq_enable, wake_req, auto_en, seen;
  logic [2:0] ack_dly;
  logic [7:0] adr, port_a_pins, port_b_pins, n_taken, rd, gm, nt, ra;
  logic [31:0] wdat, rdat;
  logic [N_PC-1:0] alt;
  imf_tmr_evt_s tmr_evt;
  imf_vec_e irq_vector, last_vec;
  int n_mismatch, n_checks, seed, j;
  logic [7:0] rmask [4] = '{8'h70, 8'h00, 8'h66, 8'h00};
  imf_vec_e pr [5] = '{VEC_EXT, VEC_T1A, VEC_T1B, VEC_T1W, VEC_T0W};

  imf_unit DUT (.mclk(mclk), .reset(reset), .avs_address(adr),
    .avs_read(rdq), .avs_write(wrq), .avs_writedata(wdat),
    .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(wreq),
    .ext_pin_in(ext_pin_in), .port_a_pins(port_a_pins),
    .port_b_pins(port_b_pins), .alt_fn_active(alt), .tmr_evt(tmr_evt),
    .irq_ack(ack), .return_from_irq_instr(ret), .sleeping(sleeping),
    .wdt_osc_tick(tick), .irq_req(irq_req), .irq_vector(irq_vector),
    .global_irq_enable(global_irq_enable), .wake_req(wake_req));
  imf_cpu_model u_cpu (.mclk(mclk), .reset(reset), .irq_req(irq_req),
    .irq_vector(irq_vector), .auto_en(auto_en), .ack_dly(ack_dly),
    .irq_ack(ack), .return_from_irq_instr(ret), .last_vec(last_vec),
    .n_taken(n_taken));

  always #2.5 mclk = ~mclk;
//////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge mclk);
    adr <= a;
    wdat <= {24'h0, d};
    wrq <= w;
    rdq <= !w;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (!wreq) break;
    end
    if (i == 20) begin
      n_mismatch++;
      test_done();
    end
    rd = rdat[7:0];
    wrq <= 1'b0;
    rdq <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    check(rd, e);
  endtask
  task automatic wait_taken(input logic [7:0] n);
    int i;
    for (i = 0; i < 50 && n_taken !== n; i++) @(negedge mclk);
    if (i == 50) begin
      n_mismatch++;
      test_done();
    end
  endtask
  task automatic evt(input int i);
    @(posedge mclk);
    tmr_evt <= imf_tmr_evt_s'(4'h8 >> i);
    @(posedge mclk);
    tmr_evt <= '0;
    cyc(1);
  endtask
  function automatic logic [7:0] tbit(input int i);
    return 8'h1 << (i == 0 ? 6 : i == 1 ? 5 : i == 2 ? 2 : 1);
  endfunction
  function automatic logic [7:0] pc_exp(input int j, input logic [7:0] m,
      input logic [N_PC-1:0] a);
    return (m[j < 4 ? 4 : 5] && !a[j]) ? 8'h20 : 8'h00;
  endfunction

  initial begin
    {mclk, rdq, wrq, ext_pin_in, sleeping, tick, auto_en} = '0;
    {adr, wdat, port_a_pins, port_b_pins, alt, tmr_evt, ack_dly} = '0;
    {n_mismatch, n_checks} = '0;
    seed = 17;
    reset = 1'b1;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      ra = 8'h2c + 8'(4 * k);
      rchk(ra, 8'h00);
      bus(1'b1, ra, 8'hff);
      rchk(ra, rmask[k]);
      bus(1'b1, ra, 8'h00);
    end
    bus(1'b1, 8'h00, 8'hff);
    rchk(8'h00, 8'h00);
    ack_dly <= 3'h2;
    for (int i = 0; i < 4; i++) begin
      auto_en <= 1'b0;
      bus(1'b1, OFS_STATUS, 8'h00);
      bus(1'b1, OFS_TMR_MASK, tbit(i));
      evt(i);
      rchk(OFS_TMR_FLAGS, tbit(i));
      check(irq_req, 1'b0);
      bus(1'b1, OFS_STATUS, 8'h80);
      cyc(2);
      check(irq_vector, 3 + i);
      bus(1'b1, OFS_TMR_FLAGS, tbit(i));
      @(negedge mclk);
      @(negedge mclk);
      check(irq_req, i != 3);
      evt(i);
      nt = n_taken + 8'h1;
      auto_en <= 1'b1;
      wait_taken(nt);
      check(last_vec, 3 + i);
      @(negedge mclk);
      check(global_irq_enable, 1'b0);
      rchk(OFS_TMR_FLAGS, 8'h00);
      cyc(2);
      check(global_irq_enable, 1'b1);
    end
    auto_en <= 1'b0;
    bus(1'b1, OFS_STATUS, 8'h00);
    bus(1'b1, OFS_TMR_MASK, 8'h66);
    bus(1'b1, OFS_GEN_MASK, 8'h40);
    bus(1'b1, OFS_CONTROL, 8'h02);
    ext_pin_in <= 1'b1;
    cyc(2);
    ext_pin_in <= 1'b0;
    tmr_evt <= imf_tmr_evt_s'(4'hf);
    cyc(1);
    tmr_evt <= '0;
    nt = n_taken;
    auto_en <= 1'b1;
    bus(1'b1, OFS_STATUS, 8'h80);
    for (int k = 0; k < 5; k++) begin
      nt = nt + 8'h1;
      wait_taken(nt);
      check(last_vec, pr[k]);
    end
    auto_en <= 1'b0;
    cyc(8);
    bus(1'b1, OFS_STATUS, 8'h00);
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, OFS_CONTROL, 8'(m));
      bus(1'b1, OFS_GEN_FLAGS, 8'h40);
      for (int v = 1; v >= 0; v--) begin
        ext_pin_in <= v[0];
        cyc(2);
        ra = (m == 1 || m == v + 2) ? 8'h40 : 8'h00;
        rchk(OFS_GEN_FLAGS, ra);
        bus(1'b1, OFS_GEN_FLAGS, 8'h40);
      end
    end
    bus(1'b1, OFS_CONTROL, 8'h00);
    bus(1'b1, OFS_STATUS, 8'h80);
    cyc(2);
    repeat (6) begin
      @(negedge mclk);
      check(irq_req, 1'b1);
    end
    check(irq_vector, VEC_EXT);
    bus(1'b1, OFS_GEN_MASK, 8'h00);
    cyc(2);
    check(irq_req, 1'b0);
    ext_pin_in <= 1'b1;
    bus(1'b1, OFS_STATUS, 8'h00);
    for (int k = 0; k < 20; k++) begin
      j = $unsigned($random(seed)) % N_PC;
      gm = 8'($random(seed)) & 8'h30;
      alt <= N_PC'($random(seed));
      bus(1'b1, OFS_GEN_MASK, gm);
      bus(1'b1, OFS_GEN_FLAGS, 8'h20);
      if (j < 8) port_b_pins[j] <= ~port_b_pins[j];
      else port_a_pins[j == 8 ? 3 : j - 3] <= ~port_a_pins[j == 8 ? 3 : j - 3];
      cyc(2);
      rchk(OFS_GEN_FLAGS, pc_exp(j, gm, alt));
    end
    bus(1'b1, OFS_GEN_MASK, 8'h30);
    bus(1'b1, OFS_GEN_FLAGS, 8'h20);
    alt <= '0;
    nt = n_taken + 8'h1;
    auto_en <= 1'b1;
    bus(1'b1, OFS_STATUS, 8'h80);
    port_b_pins[0] <= ~port_b_pins[0];
    wait_taken(nt);
    check(last_vec, VEC_PINCHG);
    auto_en <= 1'b0;
    cyc(8);
    bus(1'b1, OFS_STATUS, 8'h00);
    bus(1'b1, OFS_GEN_MASK, 8'h40);
    sleeping <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      if (k == 4) bus(1'b1, OFS_CONTROL, 8'h03);
      ext_pin_in <= (k == 1 || k > 3);
      tick <= 1'b1;
      @(posedge mclk);
      tick <= 1'b0;
      seen = 1'b0;
      repeat (3) begin
        @(negedge mclk);
        seen = seen | wake_req;
      end
      check(seen, k == 3 || k == 5);
      @(posedge mclk);
    end
    test_done();
  end
endmodule // imf_unit_tb_top
